// file: common/ctr_pkg.sv
// Package with register map, field layout, modes and constants for the counter/timer block
package ctr_pkg;
  // Number of channels
  localparam int NUM_CH = 2;
  // Register byte offsets, per channel stride 0x20
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_LIMIT = 5'h04;
  localparam logic [4:0] OFF_WIDTH = 5'h08;
  localparam logic [4:0] OFF_COUNT = 5'h0c;
  localparam logic [4:0] OFF_RESULT = 5'h10;
  localparam logic [4:0] OFF_RESULT2 = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  // Control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_GATE_POL = 5;
  localparam int CTRL_START_SRC = 6;
  localparam int CTRL_START_FALL = 7;
  localparam int CTRL_STOP_SRC = 8;
  localparam int CTRL_STOP_FALL = 9;
  localparam int CTRL_OUT_POL = 10;
  localparam int CTRL_USE_GATE = 11;
  // Status field positions
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0002;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0001;
  // Operating modes
  typedef enum logic [3:0] {
    MODE_IDLE = 4'h0,
    MODE_EVT_GATED = 4'h1,
    MODE_EVT_FREE = 4'h2,
    MODE_UPDOWN = 4'h3,
    MODE_FREQ = 4'h4,
    MODE_PERIOD = 4'h5,
    MODE_EDGE = 4'h6,
    MODE_EDGE_CONT = 4'h7,
    MODE_PULSE_CONT = 4'h8,
    MODE_ONE_SHOT = 4'h9,
    MODE_ONE_SHOT_REP = 4'ha
  } mode_t;
  // Measurement phases, Gray coded along the usual path
  typedef enum logic [1:0] {
    PH_ARM = 2'b00,
    PH_RUN = 2'b01,
    PH_SECOND = 2'b11,
    PH_DONE = 2'b10
  } phase_t;
endpackage

// file: common/ctr_cfg_if.sv
// Interface carrying one channel's configuration and results
`timescale 1ns/10ps
interface ctr_cfg_if;
  logic [31:0] ctrl; // Control word
  logic [31:0] limit; // Period for the pulse output modes
  logic [31:0] width; // Active pulse length for outputs
  logic clear_done; // Pulse: done read-clear
  logic restart; // Pulse: control written
  logic [31:0] count; // Live count
  logic [31:0] result; // Latched result
  logic [31:0] result2; // Second latched result
  logic done; // Sticky done
  logic busy; // Channel active
  modport regs (output ctrl, limit, width, clear_done, restart,
                input count, result, result2, done, busy);
  modport chan (input ctrl, limit, width, clear_done, restart,
                output count, result, result2, done, busy);
endinterface

// file: rtl/ctr_channel.sv
// One counter/timer channel: counting, measurement and pulse output
`timescale 1ns/10ps
module ctr_channel
  import ctr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cnt_pin,
  input wire logic i_gate_pin,
  ctr_cfg_if.chan cfg,
  output logic o_out
);
  // Whole channel state
  typedef struct packed {
    logic [1:0] cnt_sync; // Count input synchroniser
    logic [1:0] gate_sync; // Gate input synchroniser
    logic cnt_prev; // Edge detect history
    logic gate_prev;
    logic [31:0] count;
    logic [31:0] result;
    logic [31:0] result2;
    logic done;
    phase_t phase;
    logic out;
  } chan_state_t;
  chan_state_t s;
  chan_state_t next_s;
  mode_t mode;
  logic en, gate_act, cnt_rise, gate_rise, gate_fall, cnt_fall, start_ev, stop_ev;

  // Select an edge from source and polarity
  function automatic logic pick_edge(input logic src_gate, input logic fall,
                                     input logic cr, input logic cf,
                                     input logic gr, input logic gf);
    if (src_gate) begin
      pick_edge = fall ? gf : gr;
    end else begin
      pick_edge = fall ? cf : cr;
    end
  endfunction

  // Decode control and edges from synchronised pins only
  always_comb begin
    mode = mode_t'(cfg.ctrl[CTRL_MODE_LSB +: 4]);
    en = cfg.ctrl[CTRL_EN];
    cnt_rise = s.cnt_sync[1] & ~s.cnt_prev; // R10
    cnt_fall = ~s.cnt_sync[1] & s.cnt_prev;
    gate_rise = s.gate_sync[1] & ~s.gate_prev;
    gate_fall = ~s.gate_sync[1] & s.gate_prev;
    gate_act = s.gate_sync[1] ^ cfg.ctrl[CTRL_GATE_POL];
    start_ev = pick_edge(cfg.ctrl[CTRL_START_SRC], cfg.ctrl[CTRL_START_FALL],
                         cnt_rise, cnt_fall, gate_rise, gate_fall);
    stop_ev = pick_edge(cfg.ctrl[CTRL_STOP_SRC], cfg.ctrl[CTRL_STOP_FALL],
                        cnt_rise, cnt_fall, gate_rise, gate_fall);
  end

  // Next-state logic for all modes
  always_comb begin
    next_s = s;
    next_s.cnt_sync = {s.cnt_sync[0], i_cnt_pin}; // R10
    next_s.gate_sync = {s.gate_sync[0], i_gate_pin}; // R10
    next_s.cnt_prev = s.cnt_sync[1];
    next_s.gate_prev = s.gate_sync[1];
    if (cfg.clear_done) begin
      next_s.done = 1'b0;
    end
    if (cfg.restart || !en) begin
      // Fresh start on any control write or while disabled
      next_s.count = 32'h0000_0000;
      next_s.phase = PH_ARM;
      next_s.out = 1'b0;
    end else begin
      case (mode)
        MODE_EVT_GATED: begin
          if (cnt_rise && gate_act) next_s.count = s.count + 32'h1; // R2
        end
        MODE_EVT_FREE: begin
          if (cnt_rise) next_s.count = s.count + 32'h1; // R3
        end
        MODE_UPDOWN: begin
          if (cnt_rise) begin
            // Gate high counts up, low counts down
            next_s.count = s.gate_sync[1] ? s.count + 32'h1 : s.count - 32'h1; // R4
          end
        end
        MODE_FREQ: begin
          // Count edges while the known-length gate pulse is active
          if (s.phase == PH_ARM && gate_act) next_s.phase = PH_RUN;
          if (s.phase != PH_DONE && gate_act && cnt_rise) begin
            next_s.count = s.count + 32'h1; // R5
          end
          if (s.phase == PH_RUN && !gate_act) begin
            next_s.result = s.count; // R11
            next_s.done = 1'b1; // R11
            next_s.phase = PH_DONE;
          end
        end
        MODE_PERIOD: begin
          // Active phase from gate polarity; result is active, result2 period
          if (s.phase == PH_ARM && gate_act && !(s.gate_prev ^ cfg.ctrl[CTRL_GATE_POL])) begin
            next_s.phase = PH_RUN;
            next_s.count = 32'h1;
          end else if (s.phase == PH_RUN) begin
            next_s.count = s.count + 32'h1; // R10
            if (!gate_act) begin
              next_s.result = s.count; // R6
              next_s.phase = PH_SECOND;
            end
          end else if (s.phase == PH_SECOND) begin
            next_s.count = s.count + 32'h1;
            if (gate_act) begin
              next_s.result2 = s.count; // R6
              next_s.done = 1'b1; // R11
              next_s.phase = PH_DONE;
            end
          end
        end
        MODE_EDGE: begin
          if (s.phase == PH_ARM && start_ev) begin
            next_s.phase = PH_RUN; // R7
            next_s.count = 32'h1;
          end else if (s.phase == PH_RUN) begin
            next_s.count = s.count + 32'h1; // R10
            if (stop_ev) begin
              next_s.result = s.count; // R7
              next_s.done = 1'b1; // R11
              next_s.phase = PH_DONE;
            end
          end
        end
        MODE_EDGE_CONT: begin
          if (start_ev) begin
            // Each start edge closes one interval and opens the next
            if (s.phase == PH_RUN) begin
              next_s.result = s.count; // R8
              next_s.done = 1'b1; // R11
            end
            next_s.phase = PH_RUN;
            next_s.count = 32'h1; // R8
          end else if (s.phase == PH_RUN) begin
            next_s.count = s.count + 32'h1;
          end
        end
        MODE_PULSE_CONT, MODE_ONE_SHOT, MODE_ONE_SHOT_REP: begin
          // Gate optionally qualifies generation; one-shots trigger on gate
          if (s.phase == PH_ARM) begin
            if (mode == MODE_PULSE_CONT ? (!cfg.ctrl[CTRL_USE_GATE] || gate_act)
                : (!cfg.ctrl[CTRL_USE_GATE] || (gate_act && !(s.gate_prev
                   ^ cfg.ctrl[CTRL_GATE_POL])))) begin
              next_s.phase = PH_RUN; // R9
              next_s.count = 32'h0;
            end
          end else if (s.phase == PH_RUN) begin
            next_s.count = s.count + 32'h1;
            next_s.out = (s.count < cfg.width); // R9
            if (mode == MODE_PULSE_CONT && cfg.ctrl[CTRL_USE_GATE] && !gate_act) begin
              next_s.phase = PH_ARM;
              next_s.out = 1'b0;
            end else if (s.count + 32'h1 >= cfg.limit) begin
              next_s.count = 32'h0;
              if (mode == MODE_ONE_SHOT) begin
                next_s.phase = PH_DONE; // R9
                next_s.done = 1'b1;
              end else if (mode == MODE_ONE_SHOT_REP) begin
                next_s.phase = PH_ARM; // R9
              end
            end
          end else begin
            next_s.out = 1'b0;
          end
        end
        default: begin
          next_s.count = s.count;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cfg.count = s.count;
  assign cfg.result = s.result;
  assign cfg.result2 = s.result2;
  assign cfg.done = s.done;
  assign cfg.busy = (s.phase == PH_RUN) || (s.phase == PH_SECOND);
  assign o_out = s.out ^ cfg.ctrl[CTRL_OUT_POL];
endmodule

// file: rtl/ctr_timer_top.sv
// Two-channel counter/timer with APB register access
//
// Functional notes
// R1 - Two independent channels, each with own pins
// R2 - Gated counting: rising edges while gate active
// R3 - Ungated counting: every rising edge, gate ignored
// R4 - Up/down: gate high up, low down
// R5 - Frequency: count edges during external gate pulse
// R6 - Period mode: active phase and full period
// R7 - Edge-to-edge: selectable start and stop edges
// R8 - Continuous: measure between successive start edges
// R9 - Pulse output: continuous, one-shot, repeated one-shot
// R10 - Measure clock cycles; synchronise pins first
// R11 - Completion latches result and sets done
`timescale 1ns/10ps
module ctr_timer_top
  import ctr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [NUM_CH-1:0] i_cnt,
  input wire logic [NUM_CH-1:0] i_gate,
  output logic [NUM_CH-1:0] o_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state, all in one struct
  typedef struct packed {
    logic [NUM_CH-1:0][31:0] ctrl;
    logic [NUM_CH-1:0][31:0] limit;
    logic [NUM_CH-1:0][31:0] width;
    logic [31:0] rdata;
    logic slverr;
    logic ack; // High in the second access cycle, drives pready
  } regs_state_t;
  regs_state_t r;
  regs_state_t next_r;
  logic [NUM_CH-1:0] clr_done; // Read-clear pulse per channel
  logic [NUM_CH-1:0] restart; // Control write pulse per channel
  logic access; // APB access phase
  logic [NUM_CH-1:0][31:0] ch_count, ch_res, ch_res2;
  logic [NUM_CH-1:0] ch_done, ch_busy;

  // One wait state lets read data and error come from flops and still
  // stand at the edge that samples pready high
  assign access = i_psel & i_penable;
  assign o_pready = r.ack;
  assign o_prdata = r.rdata;
  assign o_pslverr = r.slverr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and register updates
  always_comb begin
    next_r = r;
    clr_done = '0;
    restart = '0;
    // Ready rises only in the cycle after the first access cycle
    next_r.ack = access & ~r.ack;
    if (access && !r.ack) begin
      // First access cycle: capture read data and error
      next_r.rdata = 32'h0000_0000;
      next_r.slverr = 1'b0;
      if (i_paddr[7:5] >= 3'(NUM_CH) || i_paddr[1:0] != 2'b00) begin
        // Unmapped address answers with an error
        next_r.slverr = 1'b1;
      end else if (i_paddr[4:0] == OFF_CTRL) begin
        next_r.rdata = r.ctrl[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_LIMIT) begin
        next_r.rdata = r.limit[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_WIDTH) begin
        next_r.rdata = r.width[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_COUNT) begin
        next_r.rdata = ch_count[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_RESULT) begin
        next_r.rdata = ch_res[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_RESULT2) begin
        next_r.rdata = ch_res2[i_paddr[5]];
      end else if (i_paddr[4:0] == OFF_STATUS) begin
        // Reading status clears done; a new completion in the same cycle wins
        next_r.rdata = {30'h0, ch_busy[i_paddr[5]], ch_done[i_paddr[5]]};
        if (!i_pwrite) clr_done[i_paddr[5]] = 1'b1;
      end else begin
        next_r.slverr = 1'b1;
      end
    end else if (access && i_pwrite && !r.slverr) begin
      // Writes land at the edge that samples pready high; refused ones never
      if (i_paddr[4:0] == OFF_CTRL) begin
        next_r.ctrl[i_paddr[5]] = i_pwdata;
        restart[i_paddr[5]] = 1'b1;
      end else if (i_paddr[4:0] == OFF_LIMIT) begin
        next_r.limit[i_paddr[5]] = i_pwdata;
      end else if (i_paddr[4:0] == OFF_WIDTH) begin
        next_r.width[i_paddr[5]] = i_pwdata;
      end
    end
  end

  // Register file flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r.ctrl <= {NUM_CH{CTRL_RST}};
      r.limit <= {NUM_CH{LIMIT_RST}};
      r.width <= {NUM_CH{WIDTH_RST}};
      r.rdata <= 32'h0000_0000;
      r.slverr <= 1'b0;
      r.ack <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel instances
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      ctr_cfg_if cfg_bus ();
      assign cfg_bus.ctrl = r.ctrl[g];
      assign cfg_bus.limit = r.limit[g];
      assign cfg_bus.width = r.width[g];
      // Set wins over clear inside the channel
      assign cfg_bus.clear_done = clr_done[g] & ~restart[g];
      assign cfg_bus.restart = restart[g];
      assign ch_count[g] = cfg_bus.count;
      assign ch_res[g] = cfg_bus.result;
      assign ch_res2[g] = cfg_bus.result2;
      assign ch_done[g] = cfg_bus.done;
      assign ch_busy[g] = cfg_bus.busy;
      // Independent channel per index
      ctr_channel u_ch ( // R1
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_cnt_pin(i_cnt[g]),
        .i_gate_pin(i_gate[g]),
        .cfg(cfg_bus),
        .o_out(o_out[g])
      );
    end
  endgenerate
endmodule

// file: tb/ctr_timer_top_asserts.sv
// Port-level checks of bus answers and reset state
`timescale 1ns/10ps
module ctr_timer_top_asserts
  import ctr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [NUM_CH-1:0] o_out
);
  ////////////////////////////////////////////////////////////
  // Access edge; answers show one cycle after it
  wire logic acc = i_psel && i_penable;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  rdy_wait_a: assert property (acc && !o_pready |=> o_pready)
    else $error("pready not high after one wait state");
  rdy_idle_a: assert property (!acc |-> !o_pready)
    else $error("pready high outside an access");
  bad_chan_a: assert property (acc && i_paddr[7:5] > 3'd1 |=> o_pslverr)
    else $error("no error for absent channel");
  bad_align_a: assert property (acc && i_paddr[1:0] != 2'b00 |=> o_pslverr)
    else $error("no error for unaligned address");
  gap_addr_a: assert property (acc && i_paddr[4:0] > OFF_STATUS |=> o_pslverr)
    else $error("no error for unlisted offset");
  good_addr_a: assert property (acc && i_paddr[7:5] < 3'd2 && i_paddr[1:0] == 2'b00
    && i_paddr[4:0] <= OFF_STATUS |=> !o_pslverr)
    else $error("error on mapped address");
  // Read data must stand until the next access
  rd_hold_a: assert property (!acc |=> $stable(o_prdata))
    else $error("read data moved without access");
  err_hold_a: assert property (!acc |=> $stable(o_pslverr))
    else $error("error flag moved without access");
  rst_quiet_a: assert property ($fell(i_reset) |-> o_out == '0 && o_prdata == '0
    && !o_pslverr)
    else $error("outputs not quiet after reset");
endmodule

bind ctr_timer_top ctr_timer_top_asserts i_ctr_timer_top_asserts (.i_clk(i_clk),
  .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_out(o_out));

// file: tb/ctr_pins_model.sv
// Pulse sources, gate drivers and output load for both channels
`timescale 1ns/10ps
module ctr_pins_model
  import ctr_pkg::*;
(
  input wire logic i_clk,
  input wire logic [NUM_CH-1:0] i_out,
  output logic [NUM_CH-1:0] o_cnt,
  output logic [NUM_CH-1:0] o_gate
);
  int hi_cycles [NUM_CH] = '{default: 0}; // High cycles seen per output
  // Pins always driven, never left floating
  initial begin
    o_cnt = '0;
    o_gate = '0;
  end
  ////////////////////////////////////////////////////////////
  // Load: tally high cycles; bench takes differences, never clears
  always @(posedge i_clk) begin
    for (int k = 0; k < NUM_CH; k++) begin
      hi_cycles[k] <= hi_cycles[k] + int'(i_out[k]);
    end
  end
  // Both pins of one channel, just after an edge
  task set(input int ch, input logic c, input logic g);
    @(posedge i_clk);
    o_cnt[ch] <= c;
    o_gate[ch] <= g;
  endtask
  // Pulse train of period hi+lo; idle tail lets the sync chain drain
  task edges(input int ch, input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_cnt[ch] <= 1'b1;
      repeat (hi) @(posedge i_clk);
      o_cnt[ch] <= 1'b0;
      repeat (lo - 1) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask
  // Gate pulse train with the same timing as the count train
  task gates(input int ch, input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      o_gate[ch] <= 1'b1;
      repeat (hi) @(posedge i_clk);
      o_gate[ch] <= 1'b0;
      repeat (lo - 1) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// file: tb/gated_counter_timer_measurement_tb_top.sv
// Self-checking bench for the two-channel counter/timer
`timescale 1ns/10ps
module gated_counter_timer_measurement_tb_top
  import ctr_pkg::*;
;
  logic i_clk, i_reset, psel, penable, pwrite; // Clock, reset, bus strobes
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat; // Bus data and last read
  logic pready, pslverr, rerr;
  logic [NUM_CH-1:0] cnt, gate, outp; // Channel pins
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int h0;
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  ctr_timer_top i_ctr_timer_top (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cnt(cnt),
    .i_gate(gate), .o_out(outp));
  ctr_pins_model i_ctr_pins_model (.i_clk(i_clk), .i_out(outp), .o_cnt(cnt),
    .o_gate(gate));
  ////////////////////////////////////////////////////////////
  // Verdict and end of run, the only exit
  task close_out;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles needed
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
  // One bus transfer; answer taken at the edge that sees pready high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // High cycles of output 0 over a fixed window
  task hi_win(input int n, input int exp);
    h0 = i_ctr_pins_model.hi_cycles[0];
    repeat (n) @(posedge i_clk);
    chk("out high", 32'(i_ctr_pins_model.hi_cycles[0] - h0), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {i_reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    i_reset = 1'b1;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("ctrl", 8'h00, CTRL_RST);
    rchk("limit", 8'h24, LIMIT_RST);
    rchk("width", 8'h28, WIDTH_RST);
    xfer(1'b0, 8'h1c, 32'h0);
    chk("gap err", {31'h0, rerr}, 32'h1);
    xfer(1'b0, 8'h40, 32'h0);
    chk("chan err", {31'h0, rerr}, 32'h1);
    // Free count on channel 1, gate toggling must not matter
    wr(8'h20, 32'h5);
    i_ctr_pins_model.set(1, 1'b0, 1'b1);
    i_ctr_pins_model.edges(1, 3, 2, 2);
    i_ctr_pins_model.set(1, 1'b0, 1'b0);
    i_ctr_pins_model.edges(1, 2, 2, 2);
    rchk("free count", 8'h2c, 32'h5);
    rchk("idle count", 8'h0c, 32'h0);
    // Gated count, gate active high then active low
    wr(8'h00, 32'h3);
    i_ctr_pins_model.set(0, 1'b0, 1'b1);
    i_ctr_pins_model.edges(0, 3, 2, 2);
    i_ctr_pins_model.set(0, 1'b0, 1'b0);
    i_ctr_pins_model.edges(0, 2, 2, 2);
    rchk("gated count", 8'h0c, 32'h3);
    wr(8'h00, 32'h23);
    i_ctr_pins_model.edges(0, 2, 2, 2);
    rchk("low gate count", 8'h0c, 32'h2);
    // Up four, down one
    wr(8'h00, 32'h7);
    i_ctr_pins_model.set(0, 1'b0, 1'b1);
    i_ctr_pins_model.edges(0, 4, 2, 2);
    i_ctr_pins_model.set(0, 1'b0, 1'b0);
    i_ctr_pins_model.edges(0, 1, 2, 2);
    rchk("updown", 8'h0c, 32'h3);
    // Gate pulse of known length frames four edges
    wr(8'h00, 32'h9);
    i_ctr_pins_model.set(0, 1'b0, 1'b1);
    i_ctr_pins_model.edges(0, 4, 2, 2);
    i_ctr_pins_model.set(0, 1'b0, 1'b0);
    repeat (8) @(posedge i_clk);
    rchk("freq", 8'h10, 32'h4);
    xfer(1'b0, 8'h18, 32'h0);
    chk("done set", {31'h0, rdat[0]}, 32'h1);
    xfer(1'b0, 8'h18, 32'h0);
    chk("done clear", {31'h0, rdat[0]}, 32'h0);
    // Gate high 6 of a 16-clock period
    wr(8'h00, 32'hb);
    i_ctr_pins_model.gates(0, 3, 6, 10);
    rchk("active", 8'h10, 32'h6);
    rchk("period", 8'h14, 32'h10);
    // Count rise to gate fall, 20 clocks apart
    wr(8'h00, 32'h30d);
    i_ctr_pins_model.set(0, 1'b0, 1'b1);
    repeat (5) @(posedge i_clk);
    i_ctr_pins_model.set(0, 1'b1, 1'b1);
    repeat (19) @(posedge i_clk);
    i_ctr_pins_model.set(0, 1'b1, 1'b0);
    repeat (10) @(posedge i_clk);
    rchk("edge", 8'h10, 32'h14);
    // Successive rises every 12 clocks
    wr(8'h00, 32'hf);
    i_ctr_pins_model.edges(0, 4, 4, 8);
    rchk("cont", 8'h10, 32'hc);
    // Pulse train 2 of 5, then inverted, then one shot
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h2);
    rchk("limit rw", 8'h04, 32'h5);
    wr(8'h00, 32'h11);
    repeat (10) @(posedge i_clk);
    hi_win(50, 20);
    wr(8'h00, 32'h411);
    repeat (10) @(posedge i_clk);
    hi_win(50, 30);
    wr(8'h00, 32'h0);
    repeat (5) @(posedge i_clk);
    fork
      hi_win(60, 2);
      wr(8'h00, 32'h13);
    join
    // Gate-triggered repeated one shot: one 2-clock pulse per gate rise
    wr(8'h00, 32'h815);
    fork
      hi_win(60, 6);
      i_ctr_pins_model.gates(0, 3, 2, 8);
    join
    close_out;
  end
endmodule
